// ---- src/pnp_map.vh ----
// Purpose: Constants for the card configuration control block
// Assumes: 12-bit ISA I/O addresses, 8-bit data
// Notes:   Definitions only
`ifndef PNP_MAP_VH
`define PNP_MAP_VH

// Fixed configuration ports
`define ADDR_PORT    12'h279
`define WDATA_PORT   12'hA79
`define RD_HI_ZERO   2'h0
`define RD_LO_ONES   2'h3

// Card control register indexes
`define IDX_RD_PORT  8'h00
`define IDX_ISO      8'h01
`define IDX_CMD      8'h02
`define IDX_WAKE     8'h03
`define IDX_RES      8'h04
`define IDX_STATUS   8'h05
`define IDX_HANDLE   8'h06
`define IDX_LUNIT    8'h07

// Card command bits
`define CMD_LD_RESET 0
`define CMD_WAIT_KEY 1
`define CMD_CLR_HDL  2

// Isolation and key constants
`define ISO_FIRST    8'h55
`define ISO_SECOND   8'hAA
`define SENSE_FIRST  2'h1
`define SENSE_SECOND 2'h2
`define ID_BITS      7'h48
`define BIT_LAST     3'h7
`define KEY_SEED     8'h6A
`define KEY_LAST     5'h1F
`define LUNIT_VALUE  8'h00
`define SETTLE_CYC   2'h1

// Reset values
`define HANDLE_RST   8'h00
`define RD_PORT_RST  8'h00
`define INDEX_RST    8'h00
`define BYTE_ZERO    8'h00

`endif

// ---- src/resource_rom.v ----
// Purpose: Resource and serial identifier storage, registered read
// Assumes: Contents fixed at build time
// Notes:   First nine bytes are the serial identifier
`default_nettype none
`include "pnp_map.vh"

module resource_rom #(
  parameter AW = 5
) (
  // Clock and reset
  input  wire          core_clk,
  input  wire          nrst,
  // Read port
  input  wire [AW-1:0] addr,
  output reg  [7:0]    rd_data_q
);

  ////////////////////////////////////////////////////////////////////////
  // Table, values arbitrary
  function [7:0] rom_byte;
    input [AW-1:0] a;
    begin
      case (a)
        5'h00:   rom_byte = 8'h4C;
        5'h01:   rom_byte = 8'h1E;
        5'h02:   rom_byte = 8'h2D;
        5'h03:   rom_byte = 8'h3C;
        5'h04:   rom_byte = 8'h01;
        5'h05:   rom_byte = 8'h02;
        5'h06:   rom_byte = 8'h03;
        5'h07:   rom_byte = 8'h04;
        5'h08:   rom_byte = 8'h5A;
        5'h09:   rom_byte = 8'h0A;
        5'h0A:   rom_byte = 8'h10;
        5'h0B:   rom_byte = 8'h00;
        5'h0C:   rom_byte = 8'h15;
        5'h0D:   rom_byte = 8'h4C;
        5'h0E:   rom_byte = 8'h1E;
        5'h0F:   rom_byte = 8'h00;
        5'h10:   rom_byte = 8'h01;
        5'h11:   rom_byte = 8'h00;
        default: rom_byte = 8'h79;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Registered read
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rd_data_q <= `BYTE_ZERO;
    end else begin
      rd_data_q <= rom_byte(addr);
    end
  end

endmodule // resource_rom

`default_nettype wire

// ---- src/isa_card_config_control.v ----
// Purpose: Card control registers of a jumperless ISA card
// Assumes: ISA strobes and buses are asynchronous to core_clk
// Notes:   Writes and most read side effects at the trailing strobe edge; key reset by an address port read and read data driven at the leading edge
`default_nettype none
`include "pnp_map.vh"

module isa_card_config_control #(
  parameter ROM_AW = 5
) (
  // Clock and reset
  input  wire        core_clk,
  input  wire        nrst,
  // ISA I/O cycle pins
  input  wire [11:0] sa,
  input  wire        ior_n,
  input  wire        iow_n,
  input  wire [7:0]  sd_in,
  output reg  [7:0]  sd_out_q,
  output reg         sd_oe_q,
  // Card status
  output reg         ld_reset_q,
  output reg         cfg_mode_q
);

  ////////////////////////////////////////////////////////////////////////
  // States
  localparam [3:0] ST_WAIT_KEY = 4'h1;
  localparam [3:0] ST_SLEEP    = 4'h2;
  localparam [3:0] ST_ISOLATE  = 4'h4;
  localparam [3:0] ST_CONFIG   = 4'h8;

  ////////////////////////////////////////////////////////////////////////
  // Functions
  function [7:0] key_next;
    input [7:0] k;
    begin
      key_next = {k[0] ^ k[1], k[7:1]};
    end
  endfunction

  function sel;
    input [7:0] idx;
    input [7:0] code;
    begin
      sel = (idx == code);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  reg [11:0] sa_s1_q;
  reg [11:0] sa_s2_q;
  reg [7:0]  sd_s1_q;
  reg [7:0]  sd_s2_q;
  reg        ior_s1_q;
  reg        ior_s2_q;
  reg        ior_s3_q;
  reg        iow_s1_q;
  reg        iow_s2_q;
  reg        iow_s3_q;

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sa_s1_q  <= 12'h000;
      sa_s2_q  <= 12'h000;
      sd_s1_q  <= `BYTE_ZERO;
      sd_s2_q  <= `BYTE_ZERO;
      ior_s1_q <= 1'b1;
      ior_s2_q <= 1'b1;
      ior_s3_q <= 1'b1;
      iow_s1_q <= 1'b1;
      iow_s2_q <= 1'b1;
      iow_s3_q <= 1'b1;
    end else begin
      sa_s1_q  <= sa;
      sa_s2_q  <= sa_s1_q;
      sd_s1_q  <= sd_in;
      sd_s2_q  <= sd_s1_q;
      ior_s1_q <= ior_n;
      ior_s2_q <= ior_s1_q;
      ior_s3_q <= ior_s2_q;
      iow_s1_q <= iow_n;
      iow_s2_q <= iow_s1_q;
      iow_s3_q <= iow_s2_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control state
  reg [3:0]        state_q;
  reg [7:0]        index_q;
  reg [7:0]        rd_port_q;
  reg [7:0]        handle_q;
  reg [4:0]        key_cnt_q;
  reg [7:0]        key_exp_q;
  reg [6:0]        bit_cnt_q;
  reg              pair2_q;
  reg              sensed_q;
  reg [ROM_AW-1:0] ptr_q;
  reg [1:0]        settle_q;
  reg              rdy_q;

  wire [7:0] rom_q;

  ////////////////////////////////////////////////////////////////////////
  // Cycle decode
  wire wr_ev  = iow_s2_q & ~iow_s3_q;
  wire rd_beg = ~ior_s2_q & ior_s3_q;
  wire rd_end = ior_s2_q & ~ior_s3_q;

  wire awake    = (state_q != ST_WAIT_KEY);
  wire in_iso   = (state_q == ST_ISOLATE);
  wire in_cfg   = (state_q == ST_CONFIG);
  wire hit_addr = (sa_s2_q == `ADDR_PORT);
  wire hit_wdat = awake & (sa_s2_q == `WDATA_PORT);
  wire hit_rdat = awake & (sa_s2_q[11:10] == `RD_HI_ZERO) &
                  (sa_s2_q[9:2] == rd_port_q) &
                  (sa_s2_q[1:0] == `RD_LO_ONES);

  wire       id_done = (bit_cnt_q == `ID_BITS);
  wire       cur_bit = rom_q[bit_cnt_q[2:0]];
  wire [7:0] wdata   = sd_s2_q;
  wire       iso_rd  = in_iso & ~id_done & sel(index_q, `IDX_ISO);
  wire       res_rd  = in_cfg & sel(index_q, `IDX_RES);

  ////////////////////////////////////////////////////////////////////////
  // Resource and identifier storage
  resource_rom #(
    .AW        (ROM_AW)
  ) u_rom (
    .core_clk  (core_clk),
    .nrst      (nrst),
    .addr      (ptr_q),
    .rd_data_q (rom_q)
  );

  ////////////////////////////////////////////////////////////////////////
  // Register and state logic
  wire wake_wr  = hit_wdat & wr_ev & sel(index_q, `IDX_WAKE);
  wire ptr_step = wake_wr | (hit_rdat & rd_end & (iso_rd | res_rd));

  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_q    <= ST_WAIT_KEY;
      handle_q   <= `HANDLE_RST;
      ld_reset_q <= 1'b1;
      index_q    <= `INDEX_RST;
      rd_port_q  <= `RD_PORT_RST;
      key_cnt_q  <= 5'h00;
      key_exp_q  <= `KEY_SEED;
      bit_cnt_q  <= 7'h00;
      pair2_q    <= 1'b0;
      sensed_q   <= 1'b0;
      ptr_q      <= {ROM_AW{1'b0}};
      settle_q   <= `SETTLE_CYC;
      rdy_q      <= 1'b0;
    end else begin
      ld_reset_q <= 1'b0;

      // Unlock key checker
      if (!awake && hit_addr && (wr_ev || rd_beg)) begin
        if (wr_ev && wdata == key_exp_q) begin
          if (key_cnt_q == `KEY_LAST) begin
            state_q   <= ST_SLEEP;
            key_cnt_q <= 5'h00;
            key_exp_q <= `KEY_SEED;
          end else begin
            key_cnt_q <= key_cnt_q + 5'h01;
            key_exp_q <= key_next(key_exp_q);
          end
        end else if (wr_ev && wdata == `KEY_SEED) begin
          key_cnt_q <= 5'h01;
          key_exp_q <= key_next(`KEY_SEED);
        end else begin
          key_cnt_q <= 5'h00;
          key_exp_q <= `KEY_SEED;
        end
      end

      // Index selection
      if (awake && hit_addr && wr_ev) begin
        index_q <= wdata;
      end

      // Register writes
      if (hit_wdat && wr_ev) begin
        case (index_q)
          `IDX_RD_PORT: begin
            rd_port_q <= wdata;
          end
          `IDX_CMD: begin
            if (wdata[`CMD_LD_RESET]) begin
              ld_reset_q <= 1'b1;
            end
            if (wdata[`CMD_WAIT_KEY]) begin
              state_q   <= ST_WAIT_KEY;
              key_cnt_q <= 5'h00;
              key_exp_q <= `KEY_SEED;
            end
            if (wdata[`CMD_CLR_HDL]) begin
              handle_q <= `HANDLE_RST;
            end
          end
          `IDX_WAKE: begin
            ptr_q    <= {ROM_AW{1'b0}};
            if (wdata == handle_q) begin
              if (state_q == ST_SLEEP) begin
                if (wdata == `BYTE_ZERO) begin
                  state_q   <= ST_ISOLATE;
                  bit_cnt_q <= 7'h00;
                  pair2_q   <= 1'b0;
                  sensed_q  <= 1'b0;
                end else begin
                  state_q <= ST_CONFIG;
                end
              end
            end else if (in_iso || in_cfg) begin
              state_q <= ST_SLEEP;
            end
          end
          `IDX_HANDLE: begin
            if (in_iso || in_cfg) begin
              handle_q <= wdata;
              state_q  <= ST_CONFIG;
            end
          end
          default: begin
            index_q <= index_q;
          end
        endcase
      end

      // Read side effects
      if (hit_rdat && rd_end) begin
        if (iso_rd) begin
          if (!pair2_q) begin
            pair2_q  <= 1'b1;
            sensed_q <= ~cur_bit &
                        (sd_s2_q[1:0] == `SENSE_FIRST);
          end else begin
            pair2_q <= 1'b0;
            if (~cur_bit && sensed_q &&
                sd_s2_q[1:0] == `SENSE_SECOND) begin
              state_q <= ST_SLEEP;
            end else begin
              bit_cnt_q <= bit_cnt_q + 7'h01;
              if (bit_cnt_q[2:0] == `BIT_LAST) begin
                ptr_q    <= ptr_q + {{(ROM_AW-1){1'b0}}, 1'b1};
              end
            end
          end
        end else if (res_rd) begin
          ptr_q    <= ptr_q + {{(ROM_AW-1){1'b0}}, 1'b1};
        end
      end

      // Ready flag after storage latency
      if (ptr_step) begin
        settle_q <= `SETTLE_CYC;
        rdy_q    <= 1'b0;
      end else begin
        if (settle_q != 2'h0) begin
          settle_q <= settle_q - 2'h1;
        end
        rdy_q <= (settle_q == 2'h0);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data drive
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sd_out_q <= `BYTE_ZERO;
      sd_oe_q  <= 1'b0;
    end else begin
      if (rd_end) begin
        sd_oe_q <= 1'b0;
      end else if (hit_rdat && rd_beg) begin
        case (index_q)
          `IDX_ISO: begin
            sd_oe_q  <= iso_rd & cur_bit;
            sd_out_q <= pair2_q ? `ISO_SECOND : `ISO_FIRST;
          end
          `IDX_RES: begin
            sd_oe_q  <= in_cfg;
            sd_out_q <= rom_q;
          end
          `IDX_STATUS: begin
            sd_oe_q  <= in_cfg;
            sd_out_q <= {7'h00, rdy_q};
          end
          `IDX_HANDLE: begin
            sd_oe_q  <= in_cfg;
            sd_out_q <= handle_q;
          end
          `IDX_LUNIT: begin
            sd_oe_q  <= in_cfg;
            sd_out_q <= `LUNIT_VALUE;
          end
          default: begin
            sd_oe_q  <= 1'b0;
            sd_out_q <= `BYTE_ZERO;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Status output
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cfg_mode_q <= 1'b0;
    end else begin
      cfg_mode_q <= in_cfg;
    end
  end

endmodule // isa_card_config_control

`default_nettype wire

// ---- dv/cfg_ctl_properties.sv ----
// Purpose: Port-level properties of the card control block
// Assumes: Host strobes held at least 4 cycles
// Notes:   Bound to every instance of the block
`default_nettype none

module cfg_ctl_props (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        nrst,
  // ISA pins
  input wire logic [11:0] sa,
  input wire logic        ior_n,
  input wire logic        iow_n,
  input wire logic [7:0]  sd_in,
  input wire logic [7:0]  sd_out_q,
  input wire logic        sd_oe_q,
  // Card status
  input wire logic        ld_reset_q,
  input wire logic        cfg_mode_q
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  sequence s_idle; ior_n && iow_n; endsequence
  sequence s_rd_end; $rose(ior_n); endsequence
  sequence s_quiet; ior_n [*5]; endsequence

  a_drive_needs_read: assert property (
    $rose(sd_oe_q) |-> !ior_n && !$past(ior_n))
    else $error("drive without read strobe");
  a_release_after_read: assert property (
    s_rd_end |-> ##[1:5] !sd_oe_q) else $error("drive not released");
  a_no_idle_drive: assert property (
    s_quiet |-> !sd_oe_q) else $error("drive while idle");
  a_drive_hold: assert property (
    sd_oe_q && !ior_n |=> sd_oe_q) else $error("drive dropped early");
  a_out_steady: assert property (
    sd_oe_q && $past(sd_oe_q) |-> $stable(sd_out_q))
    else $error("read data moved");
  a_pulse_single: assert property (
    $rose(ld_reset_q) |=> !ld_reset_q) else $error("pulse too long");
  a_pulse_quiet: assert property (
    $rose(ld_reset_q) |-> s_idle) else $error("pulse mid strobe");
  a_mode_quiet: assert property (
    $changed(cfg_mode_q) |-> s_idle) else $error("mode mid strobe");
  a_write_no_drive: assert property (
    (!iow_n) [*3] |-> !sd_oe_q) else $error("drive during write");
endmodule // cfg_ctl_props

bind isa_card_config_control cfg_ctl_props props (
  .core_clk(core_clk), .nrst(nrst), .sa(sa), .ior_n(ior_n),
  .iow_n(iow_n), .sd_in(sd_in), .sd_out_q(sd_out_q),
  .sd_oe_q(sd_oe_q), .ld_reset_q(ld_reset_q), .cfg_mode_q(cfg_mode_q));
`default_nettype wire

// ---- dv/isa_host.sv ----
// Purpose: Host CPU model issuing ISA I/O cycles
// Assumes: Pins change at the falling clock edge
// Notes:   Undriven data bus is pulled up to all ones
`default_nettype none
`include "pnp_map.vh"

module isa_host (
  // Clock
  input wire logic        core_clk,
  // ISA pins
  output logic     [11:0] sa,
  output logic            ior_n,
  output logic            iow_n,
  output logic     [7:0]  sd_in,
  input wire logic [7:0]  sd_out_q,
  input wire logic        sd_oe_q
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       drv = 1'b0;
  logic [7:0] wd = 8'h00;
  logic [7:0] rd_q;
  logic [7:0] rp = 8'h00;
  // Other card's drive; all ones is the bus pull-up
  logic [7:0] rv = 8'hFF;
  assign sd_in = drv ? wd : (sd_oe_q ? sd_out_q : rv);
  initial begin
    sa = 12'h000;
    ior_n = 1'b1;
    iow_n = 1'b1;
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    cyc(1);
    sa = a;
    wd = d;
    drv = 1'b1;
    iow_n = 1'b0;
    cyc(5);
    iow_n = 1'b1;
    cyc(5);
    drv = 1'b0;
    cyc(4);
  endtask
  task automatic rd(input logic [11:0] a);
    cyc(1);
    sa = a;
    ior_n = 1'b0;
    cyc(7);
    rd_q = sd_in;
    ior_n = 1'b1;
    cyc(9);
  endtask
  task automatic reg_wr(input logic [7:0] i, input logic [7:0] d);
    wr(`ADDR_PORT, i);
    wr(`WDATA_PORT, d);
    if (i == `IDX_RD_PORT) begin
      rp = d;
    end
  endtask
  task automatic reg_rd(input logic [7:0] i);
    wr(`ADDR_PORT, i);
    rd({2'b00, rp, 2'b11});
  endtask
  task automatic key(input int n);
    logic [7:0] k;
    k = `KEY_SEED;
    repeat (n) begin
      wr(`ADDR_PORT, k);
      k = {k[0] ^ k[1], k[7:1]};
    end
  endtask
endmodule // isa_host
`default_nettype wire

// ---- dv/tb.sv ----
// Purpose: Self-checking bench for the card control block
// Assumes: One card under test; host rv stands in for another card
// Notes:   Read results are checked through a queue
`default_nettype none
`include "pnp_map.vh"
`define CHK(a, e) \
  begin \
    compares++; \
    if ((a) !== (e)) begin \
      fails++; \
      $display("mismatch at %0t: got %h want %h", $time, a, e); \
    end \
  end

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk = 1'b0;
  logic        nrst = 1'b0;
  wire logic [11:0] sa;
  wire logic        ior_n;
  wire logic        iow_n;
  wire logic [7:0]  sd_in;
  wire logic [7:0]  sd_out_q;
  wire logic        sd_oe_q;
  wire logic        ld_reset_q;
  wire logic        cfg_mode_q;
  int          fails = 0;
  int          compares = 0;
  int          pulses = 0;
  int          p0;
  logic [7:0]  h;
  logic [7:0]  want;
  logic [7:0]  exp_q[$];
  logic [7:0]  res[3] = '{8'h4C, 8'h1E, 8'h2D};
  logic [7:0]  wo[3] = '{`IDX_RD_PORT, `IDX_CMD, `IDX_WAKE};

  always #2 core_clk = ~core_clk;
  isa_host host (.core_clk(core_clk), .sa(sa), .ior_n(ior_n),
    .iow_n(iow_n), .sd_in(sd_in), .sd_out_q(sd_out_q),
    .sd_oe_q(sd_oe_q));
  isa_card_config_control dut (.core_clk(core_clk),
    .nrst(nrst), .sa(sa), .ior_n(ior_n), .iow_n(iow_n),
    .sd_in(sd_in), .sd_out_q(sd_out_q), .sd_oe_q(sd_oe_q),
    .ld_reset_q(ld_reset_q), .cfg_mode_q(cfg_mode_q));

  always @(posedge core_clk) begin
    if (nrst && ld_reset_q) begin
      pulses++;
    end
  end
  always @(posedge ior_n) begin
    if (nrst && exp_q.size() > 0) begin
      want = exp_q.pop_front();
      `CHK(host.rd_q, want)
    end
  end

  task automatic rx(input logic [7:0] i, input logic [7:0] e);
    exp_q.push_back(e);
    host.reg_rd(i);
  endtask
  task automatic end_of_test;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    #200000;
    fails++;
    end_of_test();
  end
  ////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(81333));
    repeat (10) @(negedge core_clk);
    nrst = 1'b1;
    host.cyc(3);
    `CHK(cfg_mode_q, 1'b0)
    host.key(31);
    exp_q.push_back(8'hFF);
    host.rd(`ADDR_PORT);
    host.wr(`ADDR_PORT, 8'h39);
    host.reg_wr(`IDX_WAKE, 8'h00);
    rx(`IDX_LUNIT, 8'hFF);
    `CHK(cfg_mode_q, 1'b0)
    host.key(32);
    host.reg_wr(`IDX_RD_PORT, 8'h80 | 8'($urandom));
    host.reg_wr(`IDX_WAKE, 8'h00);
    for (int i = 0; i < 4; i++) begin
      rx(`IDX_ISO, i[1] ? `ISO_FIRST : 8'hFF);
      rx(`IDX_ISO, i[1] ? `ISO_SECOND : 8'hFF);
    end
    h = 8'($urandom % 255 + 1);
    host.reg_wr(`IDX_HANDLE, h);
    `CHK(cfg_mode_q, 1'b1)
    rx(`IDX_HANDLE, h);
    host.reg_wr(`IDX_LUNIT, 8'h5A);
    rx(`IDX_LUNIT, `LUNIT_VALUE);
    foreach (wo[i]) begin
      rx(wo[i], 8'hFF);
    end
    rx(8'h20, 8'hFF);
    for (int n = 0; n < 2; n++) begin
      host.reg_wr(`IDX_WAKE, h);
      foreach (res[i]) begin
        rx(`IDX_STATUS, 8'h01);
        rx(`IDX_RES, res[i]);
      end
    end
    p0 = pulses;
    host.reg_wr(`IDX_CMD, 8'h01);
    `CHK(pulses, p0 + 1)
    rx(`IDX_HANDLE, h);
    host.reg_wr(`IDX_CMD, 8'h04);
    rx(`IDX_HANDLE, 8'h00);
    `CHK(pulses, p0 + 1)
    host.reg_wr(`IDX_CMD, 8'h02);
    `CHK(cfg_mode_q, 1'b0)
    rx(`IDX_LUNIT, 8'hFF);
    host.key(32);
    host.reg_wr(`IDX_WAKE, 8'h00);
    host.rv = `ISO_FIRST;
    rx(`IDX_ISO, `ISO_FIRST);
    host.rv = `ISO_SECOND;
    rx(`IDX_ISO, `ISO_SECOND);
    host.rv = 8'hFF;
    host.reg_wr(`IDX_HANDLE, h);
    `CHK(cfg_mode_q, 1'b0)
    host.reg_wr(`IDX_WAKE, 8'h00);
    host.reg_wr(`IDX_HANDLE, h);
    `CHK(cfg_mode_q, 1'b1)
    nrst = 1'b0;
    host.cyc(2);
    `CHK(ld_reset_q, 1'b1)
    nrst = 1'b1;
    host.cyc(3);
    `CHK(cfg_mode_q, 1'b0)
    rx(`IDX_LUNIT, 8'hFF);
    host.cyc(4);
    end_of_test();
  end
endmodule // tb
`default_nettype wire
